// File: rtl/lcd_write_target.sv
// write target end: start/stop detect, address match, command and data bytes
// assumes link lines arrive asynchronously; ram and command decode sit outside
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module lcd_write_target
   import lcd_link_pkg::*;
#(
   parameter int PTR_MAX = RAM_WORDS - 1
)
(
   input wire logic clk,
   input wire logic arst_n,
   lcd_link_if.target link,
   input wire logic address_select_pin,
   input wire logic subaddress_pin_bit0,
   input wire logic subaddress_pin_bit1,
   input wire logic subaddress_pin_bit2,
   input wire logic [PTR_W-1:0] ptr_load,
   input wire logic ptr_load_en,
   input wire logic [SUB_W-1:0] sub_load,
   input wire logic sub_load_en,
   output logic cmd_valid,
   output logic [7:0] cmd_byte,
   output logic ram_we,
   output logic [PTR_W-1:0] ram_addr,
   output logic [7:0] ram_data,
   output logic busy
);
   import lcd_link_pkg::*;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_ADDR = 5'b00010,
      ST_CMD  = 5'b00100,
      ST_DATA = 5'b01000,
      ST_SKIP = 5'b10000
   } state_t;

   logic [2:0] scl_s_q, sda_s_q;
   logic [2:0] scl_s_d, sda_s_d;
   state_t state_q, state_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d;
   logic ack_q, ack_d;
   logic ack_pend_q, ack_pend_d;
   logic busy_q, busy_d;
   logic [7:0] strap_s_q, strap_s_d;
   logic [PTR_W-1:0] ptr_q, ptr_d;
   logic [SUB_W-1:0] sub_q, sub_d;
   logic cmd_valid_q, cmd_valid_d, ram_we_q, ram_we_d;
   logic [7:0] out_q, out_d;
   logic [PTR_W-1:0] addr_q, addr_d;
   logic scl, sda, scl_rise, scl_fall, start_c, stop_c;
   logic [SUB_W-1:0] hw_sub;
   logic sel_s;

   // two-stage synchronisers plus a history stage
   assign scl_s_d = {scl_s_q[1:0], link.scl};
   assign sda_s_d = {sda_s_q[1:0], link.sda};
   assign scl = scl_s_q[1];
   assign sda = sda_s_q[1];
   assign scl_rise = scl_s_q[1] & ~scl_s_q[2];
   assign scl_fall = ~scl_s_q[1] & scl_s_q[2];
   assign start_c = scl & scl_s_q[2] & ~sda & sda_s_q[2];
   assign stop_c = scl & scl_s_q[2] & sda & ~sda_s_q[2];
   // strap pins are board levels: two flops before the decoder reads them
   assign strap_s_d = {strap_s_q[3:0], address_select_pin, subaddress_pin_bit2, subaddress_pin_bit1, subaddress_pin_bit0};
   assign hw_sub = strap_s_q[6:4];
   assign sel_s = strap_s_q[7];

   // receive state machine
   always_comb
   begin
      state_d = state_q;
      bit_d = bit_q;
      sh_d = sh_q;
      ack_d = ack_q;
      ack_pend_d = ack_pend_q;
      ptr_d = ptr_load_en ? ptr_load : ptr_q;
      sub_d = sub_load_en ? sub_load : sub_q;
      cmd_valid_d = 1'b0;
      ram_we_d = 1'b0;
      out_d = out_q;
      addr_d = addr_q;
      if (start_c)
      begin
         state_d = ST_ADDR;
         bit_d = 4'h0;
         ack_d = 1'b0;
         ack_pend_d = 1'b0;
      end
      else if (stop_c)
      begin
         state_d = ST_IDLE;
         ack_d = 1'b0;
         ack_pend_d = 1'b0;
      end
      else if (state_q != ST_IDLE && state_q != ST_SKIP)
      begin
         if (scl_rise && bit_q < 4'(BYTE_BITS))
         begin
            sh_d = {sh_q[6:0], sda};
            bit_d = bit_q + 4'h1;
         end
         else if (scl_fall && bit_q == 4'(BYTE_BITS))
         begin
            // byte complete: decide ack on the falling edge
            bit_d = 4'h9;
            case (state_q)
               ST_ADDR:
               begin
                  if (sh_q[7:2] == TARGET_ADDR_HI && sh_q[1] == sel_s && !sh_q[0])
                  begin
                     ack_d = 1'b1;
                     state_d = ST_CMD;
                  end
                  else
                     state_d = ST_SKIP;
               end
               ST_CMD:
               begin
                  ack_d = 1'b1;
                  cmd_valid_d = 1'b1;
                  out_d = sh_q;
                  if (!sh_q[7])
                     state_d = ST_DATA;
               end
               ST_DATA:
               begin
                  if (sub_q == hw_sub && ptr_q <= PTR_W'(PTR_MAX))
                  begin
                     ack_d = 1'b1;
                     ram_we_d = 1'b1;
                     out_d = sh_q;
                     addr_d = ptr_q;
                  end
                  if (ptr_q >= PTR_W'(PTR_MAX))
                  begin
                     ptr_d = '0; // wrap into next subaddress
                     sub_d = sub_q + 1'b1;
                  end
                  else
                     ptr_d = ptr_q + 1'b1;
               end
               default: state_d = ST_SKIP;
            endcase
         end
         else if (scl_rise && bit_q == 4'h9)
            ack_pend_d = 1'b1; // ack clock high seen
         else if (scl_fall && ack_pend_q)
         begin
            ack_d = 1'b0; // release after ack pulse
            ack_pend_d = 1'b0;
            bit_d = 4'h0;
         end
      end
      busy_d = (state_d != ST_IDLE);
   end

   // register all state
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
         state_q <= ST_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         ack_q <= 1'b0;
         ack_pend_q <= 1'b0;
         busy_q <= 1'b0;
         strap_s_q <= 8'h00;
         ptr_q <= '0;
         sub_q <= '0;
         cmd_valid_q <= 1'b0;
         ram_we_q <= 1'b0;
         out_q <= 8'h00;
         addr_q <= '0;
      end
      else
      begin
         scl_s_q <= scl_s_d;
         sda_s_q <= sda_s_d;
         state_q <= state_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         ack_q <= ack_d;
         ack_pend_q <= ack_pend_d;
         busy_q <= busy_d;
         strap_s_q <= strap_s_d;
         ptr_q <= ptr_d;
         sub_q <= sub_d;
         cmd_valid_q <= cmd_valid_d;
         ram_we_q <= ram_we_d;
         out_q <= out_d;
         addr_q <= addr_d;
      end
   end

   // outputs straight from flops; only ack drives sda
   assign link.sda_tgt_o = 1'b0;
   assign link.sda_tgt_oe = ack_q;
   assign cmd_valid = cmd_valid_q;
   assign cmd_byte = out_q;
   assign ram_we = ram_we_q;
   assign ram_data = out_q;
   assign ram_addr = addr_q;
   assign busy = busy_q;
endmodule : lcd_write_target
`default_nettype wire

// File: rtl/lcd_link_pkg.sv
// constants shared by the write target and the bus controller ends
// assumes a single 200 MHz system clock on both ends
package lcd_link_pkg;
   localparam logic [5:0] TARGET_ADDR_HI = 6'h1c; // fixed upper address bits 011100
   localparam int BYTE_BITS = 8;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int LINK_PERIOD_NS = 160;
   localparam int HALF_CYCLES = (LINK_PERIOD_NS * 1000 / CLK_PERIOD_PS) / 2;
   localparam int RAM_WORDS = 40;
   localparam int RAM_WORD_BITS = 4;
   localparam int PTR_W = 6;
   localparam int SUB_W = 3;
   localparam logic [PTR_W-1:0] PTR_LAST = 6'h27; // last ram column
endpackage : lcd_link_pkg

// File: rtl/lcd_link_if.sv
// two-wire link between controller end and write target end
// assumes open-drain wires with pull-ups resolved here
`timescale 1ns/1ps
`default_nettype none
interface lcd_link_if;
   logic scl_o;
   logic scl_oe;
   logic sda_ctl_o;
   logic sda_ctl_oe;
   logic sda_tgt_o;
   logic sda_tgt_oe;
   logic scl;
   logic sda;
   // wired-and with pull-ups
   assign scl = scl_oe ? scl_o : 1'b1;
   assign sda = (sda_ctl_oe & ~sda_ctl_o) | (sda_tgt_oe & ~sda_tgt_o) ? 1'b0 : 1'b1;
   modport target (input scl, input sda, output sda_tgt_o, output sda_tgt_oe);
   modport controller (input scl, input sda, output scl_o, output scl_oe, output sda_ctl_o, output sda_ctl_oe);
endinterface : lcd_link_if
`default_nettype wire

// File: rtl/lcd_bus_controller.sv
// controller end: avalon-mm slave that sends one byte with start/stop framing
// assumes the write target end on the shared link interface
`timescale 1ns/1ps
`default_nettype none
module lcd_bus_controller
   import lcd_link_pkg::*;
#(
   parameter int HALF = HALF_CYCLES
)
(
   input wire logic clk,
   input wire logic arst_n,
   lcd_link_if.controller link,
   input wire logic [1:0] avs_address,
   input wire logic avs_write,
   input wire logic avs_read,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   import lcd_link_pkg::*;

   // reg 0 write: bit8 start before, bit9 stop after, [7:0] byte; read: bit0 busy, bit1 last nack
   localparam logic [1:0] REG_XFER = 2'h0;
   localparam int F_START = 8;
   localparam int F_STOP = 9;

   typedef enum logic [3:0] {
      C_IDLE = 4'b0001, C_START = 4'b0010, C_BIT = 4'b0100, C_STOP = 4'b1000
   } cstate_t;

   cstate_t st_q, st_d;
   logic [15:0] cnt_q, cnt_d;
   logic [1:0] ph_q, ph_d;
   logic [3:0] bit_q, bit_d;
   logic [8:0] sh_q, sh_d;
   logic stop_q, stop_d, nack_q, nack_d;
   logic scl_q, scl_d, sdal_q, sdal_d;
   logic [31:0] rd_q, rd_d;
   logic wait_q, wait_d;
   logic [1:0] sda_s_q;
   logic tick;

   assign tick = (cnt_q == 16'(HALF - 1));

   // bus and link sequencer; ack bit is sampled on the ninth high phase
   always_comb
   begin
      st_d = st_q;
      cnt_d = tick ? 16'h0000 : cnt_q + 16'h0001;
      ph_d = ph_q;
      bit_d = bit_q;
      sh_d = sh_q;
      stop_d = stop_q;
      nack_d = nack_q;
      scl_d = scl_q;
      sdal_d = sdal_q;
      rd_d = {30'h0, nack_q, st_q != C_IDLE};
      wait_d = 1'b1;
      if (st_q == C_IDLE)
         cnt_d = 16'h0000;
      case (st_q)
         C_IDLE:
         begin
            if ((avs_write || avs_read) && wait_q)
               wait_d = 1'b0;
            if (avs_write && wait_q && avs_address == REG_XFER)
            begin
               sh_d = {avs_writedata[7:0], 1'b1};
               stop_d = avs_writedata[F_STOP];
               bit_d = 4'h0;
               ph_d = 2'h0;
               st_d = avs_writedata[F_START] ? C_START : C_BIT;
            end
         end
         C_START:
            if (tick)
            begin
               // sda falls while scl high, then scl falls
               if (ph_q == 2'h0)
               begin
                  sdal_d = 1'b0;
                  scl_d = 1'b1;
                  ph_d = 2'h1;
               end
               else if (ph_q == 2'h1)
               begin
                  sdal_d = 1'b1;
                  ph_d = 2'h2;
               end
               else
               begin
                  scl_d = 1'b0;
                  ph_d = 2'h0;
                  st_d = C_BIT;
               end
            end
         C_BIT:
            if (tick)
            begin
               // data changes while scl is low, except for a byte sent without start after reset or a stop
               if (ph_q == 2'h0)
               begin
                  sdal_d = ~sh_q[8];
                  ph_d = 2'h1;
               end
               else if (ph_q == 2'h1)
               begin
                  scl_d = 1'b1;
                  ph_d = 2'h2;
               end
               else
               begin
                  scl_d = 1'b0;
                  ph_d = 2'h0;
                  if (bit_q == 4'h8) nack_d = sda_s_q[1];
                  sh_d = {sh_q[7:0], 1'b1};
                  bit_d = bit_q + 4'h1;
                  if (bit_q == 4'h8)
                     st_d = stop_q ? C_STOP : C_IDLE;
               end
            end
         C_STOP:
            if (tick)
            begin
               if (ph_q == 2'h0)
               begin
                  sdal_d = 1'b1;
                  ph_d = 2'h1;
               end
               else if (ph_q == 2'h1)
               begin
                  scl_d = 1'b1;
                  ph_d = 2'h2;
               end
               else
               begin
                  sdal_d = 1'b0;
                  ph_d = 2'h0;
                  st_d = C_IDLE;
               end
            end
         default: st_d = C_IDLE;
      endcase
   end

   // register state
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_q <= C_IDLE;
         cnt_q <= 16'h0000;
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         sh_q <= 9'h1ff;
         stop_q <= 1'b0;
         nack_q <= 1'b0;
         scl_q <= 1'b1;
         sdal_q <= 1'b0;
         rd_q <= 32'h0000_0000;
         wait_q <= 1'b1;
         sda_s_q <= 2'h3;
      end
      else
      begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         ph_q <= ph_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         stop_q <= stop_d;
         nack_q <= nack_d;
         scl_q <= scl_d;
         sdal_q <= sdal_d;
         rd_q <= rd_d;
         wait_q <= wait_d;
         sda_s_q <= {sda_s_q[0], link.sda};
      end
   end

   assign link.scl_o = scl_q;
   assign link.scl_oe = 1'b1;
   assign link.sda_ctl_o = 1'b0;
   assign link.sda_ctl_oe = sdal_q;
   assign avs_readdata = rd_q;
   assign avs_waitrequest = wait_q;
endmodule : lcd_bus_controller
`default_nettype wire

// File: tb/lcd_link_properties.sv
// checker: wire-level properties of the link between both ends
// assumes instantiation beside the link interface, system clock domain
`timescale 1ns/1ps
`default_nettype none
module lcd_link_properties
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_tgt_o,
   input wire logic sda_tgt_oe
);
   logic scl_q;
   logic sda_q;
   logic [3:0] rise_cnt_q;
   logic [3:0] rise_cnt_d;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // counts clock rises since the last start, wraps to zero on the rise of the ack pulse
   always_comb
   begin
      rise_cnt_d = rise_cnt_q;
      if (scl && scl_q && sda_q && !sda)
         rise_cnt_d = 4'h0;
      else if (scl && !scl_q)
         rise_cnt_d = (rise_cnt_q == 4'h8) ? 4'h0 : rise_cnt_q + 4'h1;
   end
   // line history for edge finding
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         rise_cnt_q <= 4'h0;
      end
      else
      begin
         scl_q <= scl;
         sda_q <= sda;
         rise_cnt_q <= rise_cnt_d;
      end
   end
   tgt_drive_low_a: assert property (sda_tgt_oe |-> !sda_tgt_o && (rise_cnt_q == 4'h8 || rise_cnt_q == 4'h0))
      else $error("target drives data line outside an ack bit");
   ack_ninth_bit_a: assert property (sda_tgt_oe && scl && !scl_q |-> rise_cnt_q == 4'h8)
      else $error("ack outside the ninth clock pulse");
   ack_held_high_a: assert property (sda_tgt_oe && scl |=> sda_tgt_oe || !scl)
      else $error("ack released while clock high");
   ack_setup_low_a: assert property ($rose(sda_tgt_oe) |-> !scl)
      else $error("ack raised while clock high");
   ack_release_bound_a: assert property ($rose(sda_tgt_oe) |-> ##[1:100] !sda_tgt_oe)
      else $error("ack never released");
   reset_idle_a: assert property ($rose(arst_n) |-> scl && !sda_tgt_oe)
      else $error("link not idle after reset");
   clk_high_hold_a: assert property ($rose(scl) |-> scl [*4])
      else $error("clock high phase too short");
   clk_low_hold_a: assert property ($fell(scl) |-> !scl [*4])
      else $error("clock low phase too short");
endmodule : lcd_link_properties
`default_nettype wire

// File: tb/testbench.sv
// testbench: controller end sends bytes to the write target end
// assumes default half period, a 240 ns link clock (80 ns high, 160 ns low per bit)
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import lcd_link_pkg::*;
   logic clk, arst_n, sel, ptr_en, sub_en, avs_write, avs_read, avs_waitrequest, cmd_valid, ram_we, busy;
   logic [2:0] pins, sub_ld;
   logic [5:0] ptr_ld, ram_addr, last_addr;
   logic [1:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [7:0] cmd_byte, ram_data, last_cmd, last_data;
   int n_fail, comparisons, n_cmd, n_ram;
   lcd_link_if i_lcd_link_if();
   lcd_write_target i_lcd_write_target (.clk(clk), .arst_n(arst_n), .link(i_lcd_link_if.target),
      .address_select_pin(sel), .subaddress_pin_bit0(pins[0]), .subaddress_pin_bit1(pins[1]),
      .subaddress_pin_bit2(pins[2]), .ptr_load(ptr_ld), .ptr_load_en(ptr_en), .sub_load(sub_ld),
      .sub_load_en(sub_en), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .ram_we(ram_we),
      .ram_addr(ram_addr), .ram_data(ram_data), .busy(busy));
   lcd_bus_controller i_lcd_bus_controller (.clk(clk), .arst_n(arst_n), .link(i_lcd_link_if.controller),
      .avs_address(avs_address), .avs_write(avs_write), .avs_read(avs_read), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   lcd_link_properties link_checker (.clk(clk), .arst_n(arst_n), .scl(i_lcd_link_if.scl),
      .sda(i_lcd_link_if.sda), .sda_tgt_o(i_lcd_link_if.sda_tgt_o), .sda_tgt_oe(i_lcd_link_if.sda_tgt_oe));
   task test_done();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one avalon access, held until waitrequest is seen low
   task avs(input logic wr, input logic [1:0] a, input logic [31:0] d);
      avs_write <= wr;
      avs_read <= !wr;
      avs_address <= a;
      avs_writedata <= d;
      // waitrequest and read data are both taken at the same rising edge
      do
         @(posedge clk);
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // one idle edge so the next call never reassigns in this time step
      @(posedge clk);
   endtask : avs
   // sends one framed byte, then checks idle and the ack outcome
   task send(input logic [9:0] v, input logic nk);
      avs(1'b1, 2'h0, {22'h00_0000, v});
      avs(1'b0, 2'h0, 32'h0000_0000);
      chk({30'h0000_0000, q[1:0]}, {30'h0000_0000, nk, 1'b0});
   endtask : send
   task load(input logic [5:0] p, input logic [2:0] s);
      ptr_ld <= p;
      sub_ld <= s;
      ptr_en <= 1'b1;
      sub_en <= 1'b1;
      @(posedge clk);
      ptr_en <= 1'b0;
      sub_en <= 1'b0;
      @(posedge clk);
   endtask : load
   // records target command and ram write pulses
   always @(posedge clk)
   begin
      if (cmd_valid === 1'b1)
      begin
         n_cmd++;
         last_cmd = cmd_byte;
      end
      if (ram_we === 1'b1)
      begin
         n_ram++;
         last_addr = ram_addr;
         last_data = ram_data;
      end
   end
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // watchdog sized well above the byte sequence below
   initial
   begin
      repeat (60000) @(posedge clk);
      n_fail++;
      test_done();
   end
   initial
   begin
      {arst_n, sel, ptr_en, sub_en, avs_write, avs_read} = 6'h00;
      pins = 3'h0;
      sub_ld = 3'h0;
      ptr_ld = 6'h00;
      avs_address = 2'h0;
      avs_writedata = 32'h0000_0000;
      {n_fail, comparisons, n_cmd, n_ram} = {32'h0, 32'h0, 32'h0, 32'h0};
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      send(10'h170, 1'b0);
      send(10'h080, 1'b0);
      chk(32'(last_cmd), 32'h0000_0080);
      send(10'h000, 1'b0);
      chk(32'(n_cmd), 32'h0000_0002);
      load(PTR_LAST, 3'h0);
      send(10'h0a5, 1'b0);
      chk(32'({last_addr, last_data}), 32'h0000_27a5);
      send(10'h25a, 1'b1);
      chk(32'(n_ram), 32'h0000_0001);
      repeat (4) @(posedge clk);
      chk(32'(busy), 32'h0000_0000);
      send(10'h172, 1'b1);
      send(10'h280, 1'b1);
      send(10'h371, 1'b1);
      chk(32'(n_cmd), 32'h0000_0002);
      sel <= 1'b1;
      pins <= 3'h3;
      @(posedge clk);
      send(10'h170, 1'b1);
      send(10'h172, 1'b0);
      send(10'h000, 1'b0);
      chk(32'(n_cmd), 32'h0000_0003);
      load(6'h05, 3'h3);
      send(10'h03c, 1'b0);
      send(10'h2c3, 1'b0);
      chk(32'({last_addr, last_data}), 32'h0000_06c3);
      avs(1'b0, 2'h3, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      test_done();
   end
endmodule : testbench
`default_nettype wire
